//--- src/dcc_defines.svh
// How it works
// RULE1 - per-channel wiring supervision enable bit, cleared by reset
// RULE2 - supervised wiring fault sets the lead break flag in cyclic data
// RULE3 - a reported wiring fault also raises the diagnostic alarm output
// RULE4 - optional report delay keeps a fault pending for the set time
// RULE5 - inversion setting flips the input level; off after reset
// RULE6 - rise filter time 0..60000 ms suppresses short high pulses
// RULE7 - fall stretch time 0..60000 ms stretches short pulses; default 0
// RULE8 - on fault the output goes off, on or holds; default off
// RULE9 - fault state lasts the set seconds, then goes to final state
// RULE10 - duration zero keeps the fault state forever; default zero
// RULE11 - final state selectable off or on, default off
// RULE12 - duration above 7200 s flags a parameter error
// RULE13 - filters count millisecond ticks and restart when input returns
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define DCC_CLK_HZ       50000000
`define DCC_TICK_MS      1
`define DCC_MS_CYCLES    ((`DCC_CLK_HZ / 1000) * `DCC_TICK_MS)
`define DCC_MS_PER_S     1000
`define DCC_TIME_MAX_MS  16'hea60
`define DCC_DUR_MAX_S    16'h1c20

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCC_CTRL_OFS     8'h00
`define DCC_RISE_OFS     8'h04
`define DCC_FALL_OFS     8'h08
`define DCC_DUR_OFS      8'h0c
`define DCC_RDLY_OFS     8'h10
`define DCC_STAT_OFS     8'h14
`define DCC_IRQ_ST_OFS   8'h18
`define DCC_IRQ_CLR_OFS  8'h1c
`define DCC_IRQ_EN_OFS   8'h20
`define DCC_DOUT_OFS     8'h24

// ----------------------------------------
// control fields
// ----------------------------------------
`define DCC_CTRL_SUP     0
`define DCC_CTRL_INV     1
`define DCC_CTRL_RDLY    2
`define DCC_CTRL_FS_LO   4
`define DCC_CTRL_FINAL   6
`define DCC_CTRL_RESET   32'h00000000
`define DCC_FS_OFF       2'h0
`define DCC_FS_ON        2'h1
`define DCC_FS_HOLD      2'h2

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define DCC_IRQ_W        4
`define DCC_IRQ_ALARM    0
`define DCC_IRQ_CLEARED  1
`define DCC_IRQ_FAULT    2
`define DCC_IRQ_FINAL    3

`endif

//--- src/dcc_edge_filter.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_edge_filter
    import dcc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        raw,
    input  wire logic        ms_tick,
    input  wire logic [15:0] rise_time,
    input  wire logic [15:0] fall_time,
    output logic             level
);
    dcc_filt_state_type state_reg;
    dcc_filt_state_type state_next;
    logic [15:0]        limit;

    always_comb begin
        state_next = state_reg;
        limit      = state_reg.level ? fall_time : rise_time;   // [RULE6] [RULE7]
        if (raw == state_reg.level) begin
            state_next.cnt = '0;                                // [RULE13]
        end else if (state_reg.cnt >= limit) begin
            state_next.level = raw;
            state_next.cnt   = '0;
        end else if (ms_tick) begin
            state_next.cnt = state_reg.cnt + 16'h0001;          // [RULE13]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.level;
endmodule // dcc_edge_filter
`default_nettype wire

//--- src/dcc_pkg.sv
package dcc_pkg;

    typedef enum logic [1:0] {
        dcc_out_normal,
        dcc_out_fault,
        dcc_out_final
    } dcc_out_state_type;

    typedef struct packed {
        logic        level;
        logic [15:0] cnt;
    } dcc_filt_state_type;

    typedef struct packed {
        logic              sup_en;
        logic              inv_en;
        logic              rdly_en;
        logic [1:0]        fstate;
        logic              final_on;
        logic [15:0]       rise;
        logic [15:0]       fall;
        logic [15:0]       dur;
        logic [15:0]       rdly;
        logic              dout_bus;
        logic [3:0]        irq_stat;
        logic [3:0]        irq_en;
        dcc_out_state_type st;
        logic [15:0]       sec_cnt;
        logic              hold_val;
        logic [15:0]       pend_cnt;
        logic              reported;
        logic              lead_break;
        logic              dout;
        logic              fault_d;
        logic [31:0]       prdata;
        logic              pslverr;
    } dcc_top_state_type;

endpackage

//--- src/dcc_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_tick_div
    import dcc_pkg::*;
#(
    parameter int unsigned DIV = 1000
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic clr,
    input  wire logic en,
    output logic      tick
);
    localparam int W = $clog2(DIV + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } dcc_div_state_type;

    dcc_div_state_type state_reg;
    dcc_div_state_type state_next;

    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (clr) begin
            state_next.cnt = '0;
        end else if (en) begin
            if (state_reg.cnt == W'(DIV - 1)) begin
                state_next.cnt  = '0;
                state_next.tick = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule // dcc_tick_div
`default_nettype wire

//--- src/dcc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.svh"
module dcc_top
    import dcc_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `DCC_MS_CYCLES,
    parameter int unsigned MS_PER_S  = `DCC_MS_PER_S
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        din_raw,
    input  wire logic        wire_fault,
    input  wire logic        fault_req,
    output logic             din_value,
    output logic             lead_break_flag,
    output logic             diag_alarm,
    output logic             dout,
    output logic             param_err,
    output logic             irq
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `DCC_CTRL_OFS, `DCC_RISE_OFS, `DCC_FALL_OFS,
            `DCC_DUR_OFS, `DCC_RDLY_OFS, `DCC_STAT_OFS,
            `DCC_IRQ_ST_OFS, `DCC_IRQ_CLR_OFS, `DCC_IRQ_EN_OFS,
            `DCC_DOUT_OFS: addr_ok = 1'b1;
            default:       addr_ok = 1'b0;
        endcase
    endfunction

    // filter times above the range saturate rather than wrap
    function automatic logic [15:0] sat_ms(input logic [31:0] v);
        if (v > {16'h0000, `DCC_TIME_MAX_MS}) begin
            sat_ms = `DCC_TIME_MAX_MS;
        end else begin
            sat_ms = v[15:0];
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    dcc_top_state_type         state_reg;
    dcc_top_state_type         state_next;
    logic                      ms_tick;
    logic                      s_tick;
    logic                      filt_level;
    logic                      raw_cond;
    logic                      pending;
    logic                      wr_en;
    logic                      rd_setup;
    logic                      fault_rise;
    logic [`DCC_IRQ_W-1:0]     ev;
    logic [`DCC_IRQ_W-1:0]     clr_mask;
    logic [31:0]               ctrl_rd;
    logic [31:0]               stat_rd;

    // ----------------------------------------
    // time bases
    // ----------------------------------------
    dcc_tick_div #(
        .DIV (MS_CYCLES)
    ) u_ms_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clr   (1'b0),
        .en    (1'b1),
        .tick  (ms_tick)
    );

    // restarted on fault entry so the first second is a full one
    dcc_tick_div #(
        .DIV (MS_PER_S)
    ) u_s_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clr   (fault_rise),
        .en    (ms_tick),
        .tick  (s_tick)
    );

    // ----------------------------------------
    // input path
    // ----------------------------------------
    assign raw_cond = din_raw ^ state_reg.inv_en;          // [RULE5]

    dcc_edge_filter u_filt (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .raw       (raw_cond),
        .ms_tick   (ms_tick),
        .rise_time (state_reg.rise),
        .fall_time (state_reg.fall),
        .level     (filt_level)
    );

    assign pending    = state_reg.sup_en & wire_fault;     // [RULE1]
    assign fault_rise = fault_req & ~state_reg.fault_d;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign wr_en    = psel & penable & pwrite & addr_ok(paddr);
    assign rd_setup = psel & ~penable;
    assign clr_mask = (wr_en && paddr == `DCC_IRQ_CLR_OFS) ?
                      pwdata[`DCC_IRQ_W-1:0] : '0;

    always_comb begin
        ctrl_rd                                   = '0;
        ctrl_rd[`DCC_CTRL_SUP]                    = state_reg.sup_en;
        ctrl_rd[`DCC_CTRL_INV]                    = state_reg.inv_en;
        ctrl_rd[`DCC_CTRL_RDLY]                   = state_reg.rdly_en;
        ctrl_rd[`DCC_CTRL_FS_LO+1:`DCC_CTRL_FS_LO] = state_reg.fstate;
        ctrl_rd[`DCC_CTRL_FINAL]                  = state_reg.final_on;
        stat_rd    = '0;
        stat_rd[0] = filt_level;
        stat_rd[1] = state_reg.lead_break;
        stat_rd[2] = state_reg.reported;
        stat_rd[3] = state_reg.dur > `DCC_DUR_MAX_S;
        stat_rd[4] = state_reg.st == dcc_out_fault;
        stat_rd[5] = state_reg.st == dcc_out_final;
        stat_rd[6] = state_reg.dout;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_next         = state_reg;
        ev                 = '0;
        state_next.fault_d = fault_req;

        // register writes
        if (wr_en) begin
            case (paddr)
                `DCC_CTRL_OFS: begin
                    state_next.sup_en   = pwdata[`DCC_CTRL_SUP];   // [RULE1]
                    state_next.inv_en   = pwdata[`DCC_CTRL_INV];   // [RULE5]
                    state_next.rdly_en  = pwdata[`DCC_CTRL_RDLY];  // [RULE4]
                    state_next.fstate   =
                        pwdata[`DCC_CTRL_FS_LO+1:`DCC_CTRL_FS_LO]; // [RULE8]
                    state_next.final_on = pwdata[`DCC_CTRL_FINAL]; // [RULE11]
                end
                `DCC_RISE_OFS:   state_next.rise     = sat_ms(pwdata); // [RULE6]
                `DCC_FALL_OFS:   state_next.fall     = sat_ms(pwdata); // [RULE7]
                `DCC_DUR_OFS:    state_next.dur      = pwdata[15:0];
                `DCC_RDLY_OFS:   state_next.rdly     = pwdata[15:0];
                `DCC_IRQ_EN_OFS: state_next.irq_en   = pwdata[`DCC_IRQ_W-1:0];
                `DCC_DOUT_OFS:   state_next.dout_bus = pwdata[0];
                default: begin
                end
            endcase
        end

        // read data captured in the setup phase, so zero wait states work
        if (rd_setup) begin
            state_next.pslverr = ~addr_ok(paddr);
            case (paddr)
                `DCC_CTRL_OFS:   state_next.prdata = ctrl_rd;
                `DCC_RISE_OFS:   state_next.prdata = {16'h0000, state_reg.rise};
                `DCC_FALL_OFS:   state_next.prdata = {16'h0000, state_reg.fall};
                `DCC_DUR_OFS:    state_next.prdata = {16'h0000, state_reg.dur};
                `DCC_RDLY_OFS:   state_next.prdata = {16'h0000, state_reg.rdly};
                `DCC_STAT_OFS:   state_next.prdata = stat_rd;
                `DCC_IRQ_ST_OFS: state_next.prdata = {28'h0000000, state_reg.irq_stat};
                `DCC_IRQ_EN_OFS: state_next.prdata = {28'h0000000, state_reg.irq_en};
                `DCC_DOUT_OFS:   state_next.prdata = {31'h00000000, state_reg.dout_bus};
                default:         state_next.prdata = 32'h00000000;
            endcase
        end

        // wiring supervision and report delay
        state_next.lead_break = pending;                   // [RULE2]
        if (!pending) begin
            state_next.pend_cnt = '0;
            state_next.reported = 1'b0;
        end else if (!state_reg.rdly_en ||
                     state_reg.pend_cnt >= state_reg.rdly) begin
            state_next.reported = 1'b1;                    // [RULE3] [RULE4]
        end else if (ms_tick) begin
            state_next.pend_cnt = state_reg.pend_cnt + 16'h0001; // [RULE4]
        end
        ev[`DCC_IRQ_ALARM]   = state_next.reported & ~state_reg.reported;
        ev[`DCC_IRQ_CLEARED] = ~state_next.reported & state_reg.reported;

        // output fault handling
        case (state_reg.st)
            dcc_out_normal: begin
                state_next.dout = state_reg.dout_bus;
                if (fault_req) begin
                    state_next.st       = dcc_out_fault;
                    state_next.hold_val = state_reg.dout;
                    state_next.sec_cnt  = '0;
                    ev[`DCC_IRQ_FAULT]  = 1'b1;
                end
            end
            dcc_out_fault: begin
                case (state_reg.fstate)
                    `DCC_FS_ON:   state_next.dout = 1'b1;  // [RULE8]
                    `DCC_FS_HOLD: state_next.dout = state_reg.hold_val;
                    default:      state_next.dout = 1'b0;
                endcase
                if (s_tick) begin
                    state_next.sec_cnt = state_reg.sec_cnt + 16'h0001; // [RULE9]
                end
                if (!fault_req) begin
                    state_next.st = dcc_out_normal;
                end else if (state_reg.dur != 16'h0000 &&
                             state_reg.sec_cnt >= state_reg.dur) begin
                    // zero duration never reaches the final state
                    state_next.st      = dcc_out_final;    // [RULE9] [RULE10]
                    ev[`DCC_IRQ_FINAL] = 1'b1;
                end
            end
            dcc_out_final: begin
                state_next.dout = state_reg.final_on;      // [RULE11]
                if (!fault_req) begin
                    state_next.st = dcc_out_normal;
                end
            end
            default: begin
                state_next.st = dcc_out_normal;
            end
        endcase

        // a new event wins over a clear in the same cycle
        state_next.irq_stat = (state_reg.irq_stat & ~clr_mask) | ev;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign pready          = 1'b1;
    assign prdata          = state_reg.prdata;
    assign pslverr         = state_reg.pslverr;
    assign din_value       = filt_level;
    assign lead_break_flag = state_reg.lead_break;                // [RULE2]
    assign diag_alarm      = state_reg.reported;                  // [RULE3]
    assign dout            = state_reg.dout;
    assign param_err       = state_reg.dur > `DCC_DUR_MAX_S;      // [RULE12]
    assign irq             = |(state_reg.irq_stat & state_reg.irq_en);
endmodule // dcc_top
`default_nettype wire

//--- test/dcc_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_field_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic level,
    input  wire logic broken,
    output logic      din_raw,
    output logic      wire_fault
);
    // ----------------------------------------
    // field sensor and its wiring
    // ----------------------------------------
    // a broken lead leaves the input open, so it reads low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            din_raw    <= 1'b0;
            wire_fault <= 1'b0;
        end else begin
            din_raw    <= level && !broken;
            wire_fault <= broken;
        end
    end
endmodule // dcc_field_model
`default_nettype wire

//--- test/dcc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.svh"
module dcc_top_props
    import dcc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        din_raw,
    input wire logic        wire_fault,
    input wire logic        fault_req,
    input wire logic        din_value,
    input wire logic        lead_break_flag,
    input wire logic        diag_alarm,
    input wire logic        dout,
    input wire logic        param_err,
    input wire logic        irq
);
    // ----------------------------------------
    // shadow of the settings written over the bus
    // ----------------------------------------
    logic [6:0]  ctrl_sh;
    logic [15:0] dur_sh;
    logic [1:0]  rf_sh;
    logic        rd_nz;
    logic        dout_sh;
    logic        wr;
    assign wr = psel && penable && pwrite && pready;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_sh <= '0;
            dur_sh  <= '0;
            rf_sh   <= '0;
            rd_nz   <= 1'b0;
            dout_sh <= 1'b0;
        end else if (wr) begin
            if (paddr == `DCC_CTRL_OFS) ctrl_sh <= pwdata[6:0];
            if (paddr == `DCC_DUR_OFS) dur_sh <= pwdata[15:0];
            if (paddr == `DCC_RISE_OFS) rf_sh[0] <= (pwdata[15:0] != 16'h0000);
            if (paddr == `DCC_FALL_OFS) rf_sh[1] <= (pwdata[15:0] != 16'h0000);
            if (paddr == `DCC_RDLY_OFS) rd_nz <= (pwdata[15:0] != 16'h0000);
            if (paddr == `DCC_DOUT_OFS) dout_sh <= pwdata[0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_sup_off;
        (!ctrl_sh[0])[*3] |-> !lead_break_flag && !diag_alarm;
    endproperty
    property p_lead;
        lead_break_flag == $past(ctrl_sh[0] && wire_fault);
    endproperty
    property p_alarm;
        (lead_break_flag && !ctrl_sh[2])[*2] |-> diag_alarm;
    endproperty
    property p_alarm_src;
        $rose(diag_alarm) |-> lead_break_flag;
    endproperty
    property p_delay;
        $rose(lead_break_flag) && ctrl_sh[2] && rd_nz |=> !diag_alarm;
    endproperty
    property p_inv;
        (rf_sh == 2'b00 && $stable(din_raw) && $stable(ctrl_sh[1]))[*4]
            |-> din_value == (din_raw ^ ctrl_sh[1]);
    endproperty
    property p_fs_off;
        $rose(fault_req) && ctrl_sh[5:4] != `DCC_FS_ON && ctrl_sh[5:4] != `DCC_FS_HOLD
            ##1 fault_req |=> !dout;
    endproperty
    property p_fs_on;
        $rose(fault_req) && ctrl_sh[5:4] == `DCC_FS_ON ##1 fault_req |=> dout;
    endproperty
    property p_normal;
        (!fault_req)[*3] |-> dout == $past(dout_sh);
    endproperty
    property p_param;
        param_err == (dur_sh > `DCC_DUR_MAX_S);
    endproperty
    a_sup_off: assert property (p_sup_off) else $error("supervision off but fault shown");
    a_lead: assert property (p_lead) else $error("lead break flag wrong");
    a_alarm: assert property (p_alarm) else $error("alarm missing");
    a_alarm_src: assert property (p_alarm_src) else $error("alarm without fault");
    a_delay: assert property (p_delay) else $error("alarm not delayed");
    a_inv: assert property (p_inv) else $error("input level wrong");
    a_fs_off: assert property (p_fs_off) else $error("fault state not off");
    a_fs_on: assert property (p_fs_on) else $error("fault state not on");
    a_normal: assert property (p_normal) else $error("output not bus value");
    a_param: assert property (p_param) else $error("parameter error wrong");
    c_alarm: cover property ($rose(diag_alarm));
    c_fault: cover property ($rose(fault_req) ##2 dout);
    c_param: cover property ($rose(param_err));
endmodule // dcc_top_props
`default_nettype wire

//--- test/tb_discrete_channel_conditioner.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcc_defines.svh"
module tb_discrete_channel_conditioner;
    import dcc_pkg::*;
    logic        mclk, rst_n, psel, penable, pwrite, fault_req, lvl, brk;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, din_raw, wire_fault, e;
    logic        din_value, lead_break_flag, diag_alarm, dout, param_err, irq;
    int          errors, compares, cyc;
    logic [3:0]  tab [5];

    dcc_top #(.MS_CYCLES(5), .MS_PER_S(4)) DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .din_raw(din_raw), .wire_fault(wire_fault),
        .fault_req(fault_req), .din_value(din_value), .lead_break_flag(lead_break_flag),
        .diag_alarm(diag_alarm), .dout(dout), .param_err(param_err), .irq(irq));
    dcc_field_model u_field (.mclk(mclk), .rst_n(rst_n), .level(lvl), .broken(brk),
        .din_raw(din_raw), .wire_fault(wire_fault));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the hang guard ends a wait that never sees pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(r, exp, "read");
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // drive the field level and expect the filtered level to stay put
    task automatic hold(input logic v, input int n, input logic exp);
        lvl <= v;
        repeat (n) begin
            @(posedge mclk);
            chk(din_value, exp, "filter");
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // hang guard; the whole sequence needs well under 3000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("mismatch t=%0t timeout", $time);
            print_verdict();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, fault_req, lvl, brk} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        // {fault state, bus value, expected output}
        tab = '{4'b0010, 4'b0101, 4'b1011, 4'b1000, 4'b1110};
        wt(8);
        rst_n <= 1'b1;
        rd(`DCC_CTRL_OFS, 32'h0);
        rd(`DCC_RISE_OFS, 32'h0);
        rd(`DCC_FALL_OFS, 32'h0);
        rd(`DCC_DUR_OFS, 32'h0);
        rd(`DCC_RDLY_OFS, 32'h0);
        rd(8'h3c, 32'h0);
        chk(e, 1'b1, "unmapped error");
        lvl <= 1'b1;
        wt(6);
        chk(din_value, 1'b1, "plain");
        wr(`DCC_CTRL_OFS, 32'h2);
        wt(4);
        chk(din_value, 1'b0, "inverted");
        wr(`DCC_CTRL_OFS, 32'h0);
        lvl <= 1'b0;
        wr(`DCC_RISE_OFS, 32'h3);
        hold(1'b1, 7, 1'b0);
        hold(1'b0, 2, 1'b0);
        hold(1'b1, 10, 1'b0);
        wt(14);
        chk(din_value, 1'b1, "rise");
        wr(`DCC_FALL_OFS, 32'h3);
        hold(1'b0, 7, 1'b1);
        hold(1'b1, 2, 1'b1);
        hold(1'b0, 10, 1'b1);
        wt(14);
        chk(din_value, 1'b0, "fall");
        wr(`DCC_RISE_OFS, 32'h0);
        wr(`DCC_FALL_OFS, 32'h0);
        brk <= 1'b1;
        wt(5);
        chk({lead_break_flag, diag_alarm}, 2'b00, "unsupervised");
        wr(`DCC_IRQ_EN_OFS, 32'h1);
        wr(`DCC_CTRL_OFS, 32'h1);
        wt(3);
        chk({lead_break_flag, diag_alarm}, 2'b11, "supervised");
        rd(`DCC_IRQ_ST_OFS, 32'h1);
        chk(irq, 1'b1, "irq");
        wr(`DCC_IRQ_EN_OFS, 32'h0);
        wt(1);
        chk(irq, 1'b0, "irq masked");
        wr(`DCC_IRQ_CLR_OFS, 32'h1);
        rd(`DCC_IRQ_ST_OFS, 32'h0);
        brk <= 1'b0;
        wr(`DCC_RDLY_OFS, 32'h4);
        wr(`DCC_CTRL_OFS, 32'h5);
        brk <= 1'b1;
        wt(10);
        chk({lead_break_flag, diag_alarm}, 2'b10, "pending");
        wt(30);
        chk(diag_alarm, 1'b1, "reported");
        brk <= 1'b0;
        wr(`DCC_CTRL_OFS, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(`DCC_DOUT_OFS, {31'h0, tab[i][1]});
            wr(`DCC_CTRL_OFS, {26'h0, tab[i][3:2], 4'h0});
            fault_req <= 1'b1;
            wt(4);
            chk(dout, tab[i][0], "fault state");
            fault_req <= 1'b0;
            wt(4);
            chk(dout, tab[i][1], "normal");
        end
        wr(`DCC_DUR_OFS, 32'h2);
        wr(`DCC_CTRL_OFS, 32'h40);
        fault_req <= 1'b1;
        wt(34);
        chk(dout, 1'b0, "in fault state");
        wt(25);
        chk(dout, 1'b1, "final on");
        fault_req <= 1'b0;
        wr(`DCC_CTRL_OFS, 32'h10);
        fault_req <= 1'b1;
        wt(4);
        chk(dout, 1'b1, "fault on");
        wt(55);
        chk(dout, 1'b0, "final off");
        fault_req <= 1'b0;
        wr(`DCC_DUR_OFS, 32'h0);
        wr(`DCC_CTRL_OFS, 32'h40);
        fault_req <= 1'b1;
        wt(100);
        chk(dout, 1'b0, "no final");
        fault_req <= 1'b0;
        wr(`DCC_DUR_OFS, 32'h1c20);
        wt(1);
        chk(param_err, 1'b0, "limit");
        wr(`DCC_DUR_OFS, 32'h1c21);
        wt(1);
        chk(param_err, 1'b1, "over limit");
        rd(`DCC_DUR_OFS, 32'h1c21);
        print_verdict();
    end
endmodule // tb_discrete_channel_conditioner

bind dcc_top dcc_top_props u_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din_raw(din_raw), .wire_fault(wire_fault),
    .fault_req(fault_req), .din_value(din_value), .lead_break_flag(lead_break_flag),
    .diag_alarm(diag_alarm), .dout(dout), .param_err(param_err), .irq(irq));
`default_nettype wire
